// *** common/atd_cfg.svh ***
`ifndef ATD_CFG_SVH
`define ATD_CFG_SVH

// opcodes, ten bits
`define ATD_OP_SHIFT_TO_ACC 10'h278
`define ATD_OP_POINTER_TO_ACC 10'h051
`define ATD_OP_ACC_TO_CONV 10'h239
`define ATD_OP_IRQ_ONE 10'h253
`define ATD_OP_IRQ_TWO 10'h254
`define ATD_OP_SERIAL 10'h242
`define ATD_OP_KEY_ZERO 10'h256

// register byte offsets
`define ATD_OFF_INSTR 6'h00
`define ATD_OFF_ACC 6'h04
`define ATD_OFF_BREG 6'h08
`define ATD_OFF_SHIFT 6'h0C
`define ATD_OFF_POINTER 6'h10
`define ATD_OFF_CONV 6'h14
`define ATD_OFF_CTRL 6'h18
`define ATD_OFF_IRQ_ONE 6'h1C
`define ATD_OFF_IRQ_TWO 6'h20
`define ATD_OFF_SERIAL 6'h24
`define ATD_OFF_KEY_ZERO 6'h28
`define ATD_OFF_CARRY 6'h2C
`define ATD_OFF_STATUS 6'h30

// field positions
`define ATD_CTRL_MODE_BIT 0
`define ATD_STAT_ILLEGAL_BIT 0
`define ATD_STAT_SKIP_BIT 1
`define ATD_STAT_OP_LSB 4
`define ATD_STAT_CNT_LSB 8

// reset values
`define ATD_RST_NIBBLE 4'h0
`define ATD_RST_BYTE 8'h00
`define ATD_RST_POINTER 3'h0

`endif

// *** common/atd_pkg.sv ***
`default_nettype none
package atd_pkg;

  typedef enum logic [2:0] {
    ATD_OP_NONE = 3'b000,
    ATD_OP_SHIFT = 3'b001,
    ATD_OP_POINTER = 3'b010,
    ATD_OP_CONV = 3'b011,
    ATD_OP_IRQ1 = 3'b100,
    ATD_OP_IRQ2 = 3'b101,
    ATD_OP_SER = 3'b110,
    ATD_OP_KEY0 = 3'b111
  } atd_op_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [5:0] addr;
  } atd_ahb_req_t;

  typedef struct packed {
    logic [3:0] acc;
    logic [3:0] breg;
    logic [7:0] shift;
    logic [2:0] pointer;
    logic [7:0] conv;
    logic comparator_mode_sel;
    logic [3:0] irq_ctrl_one;
    logic [3:0] irq_ctrl_two;
    logic [3:0] serial_ctrl_reg;
    logic [3:0] key_wake_ctrl_zero;
    logic carry;
    logic skip_next;
    logic illegal;
    atd_op_t last_op;
    logic [7:0] exec_cnt;
  } atd_state_t;

endpackage
`default_nettype wire

// *** design/atd_core.sv ***
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "atd_cfg.svh"

// Overview of operation
// - shift upper nibble goes to b
// - shift lower nibble goes to accumulator
// - decode pointer-to-accumulator opcode
// - pointer bits fill accumulator low three
// - pointer move clears accumulator top bit
// - decode accumulator-to-converter opcode
// - conversion mode: converter write is no-op
// - comparator mode: b high, acc low
// - decode irq control one read, single cycle
// - decode irq control two read
// - decode serial control read
// - decode key wake control zero read
module atd_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [3:0] acc_out,
  output logic [3:0] breg_out,
  output logic [7:0] conv_out,
  output logic exec_pulse
);
  import atd_pkg::*;

  atd_ahb_req_t req_reg;
  atd_ahb_req_t req_next;
  atd_state_t st_reg;
  atd_state_t st_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic exec_reg;
  logic exec_next;
  atd_op_t op;
  logic wr_now;
  logic instr_wr;

  atd_opcode_decode u_dec (
    .opcode(hwdata[9:0]),
    .op(op)
  );

  // the slave never stalls, so hready only matters for the address phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;
  assign acc_out = st_reg.acc;
  assign breg_out = st_reg.breg;
  assign conv_out = st_reg.conv;
  assign exec_pulse = exec_reg;

  // address phase is registered so decode sees the data-phase word
  assign wr_now = req_reg.valid && req_reg.write;
  assign instr_wr = wr_now && (req_reg.addr == `ATD_OFF_INSTR);

  always_comb begin
    req_next = req_reg;
    if (hready) begin
      req_next.valid = hsel && htrans[1] && (hsize == 3'b010);
      req_next.write = hwrite;
      req_next.addr = {haddr[5:2], 2'b00};
    end
  end

  // register writes, then instruction execution in the same data phase
  always_comb begin
    st_next = st_reg;
    exec_next = 1'b0;
    if (wr_now) begin
      if (req_reg.addr == `ATD_OFF_ACC) begin
        st_next.acc = hwdata[3:0];
      end else if (req_reg.addr == `ATD_OFF_BREG) begin
        st_next.breg = hwdata[3:0];
      end else if (req_reg.addr == `ATD_OFF_SHIFT) begin
        st_next.shift = hwdata[7:0];
      end else if (req_reg.addr == `ATD_OFF_POINTER) begin
        st_next.pointer = hwdata[2:0];
      end else if (req_reg.addr == `ATD_OFF_CONV) begin
        st_next.conv = hwdata[7:0];
      end else if (req_reg.addr == `ATD_OFF_CTRL) begin
        st_next.comparator_mode_sel = hwdata[`ATD_CTRL_MODE_BIT];
      end else if (req_reg.addr == `ATD_OFF_IRQ_ONE) begin
        st_next.irq_ctrl_one = hwdata[3:0];
      end else if (req_reg.addr == `ATD_OFF_IRQ_TWO) begin
        st_next.irq_ctrl_two = hwdata[3:0];
      end else if (req_reg.addr == `ATD_OFF_SERIAL) begin
        st_next.serial_ctrl_reg = hwdata[3:0];
      end else if (req_reg.addr == `ATD_OFF_KEY_ZERO) begin
        st_next.key_wake_ctrl_zero = hwdata[3:0];
      end else if (req_reg.addr == `ATD_OFF_CARRY) begin
        st_next.carry = hwdata[0];
      end else if (req_reg.addr == `ATD_OFF_STATUS) begin
        // write one to clear; skip flag is software-owned here
        if (hwdata[`ATD_STAT_ILLEGAL_BIT]) begin
          st_next.illegal = 1'b0;
        end
        st_next.skip_next = hwdata[`ATD_STAT_SKIP_BIT];
      end
    end
    if (instr_wr) begin
      // whole instruction retires at this one edge
      exec_next = 1'b1;
      st_next.last_op = op;
      st_next.exec_cnt = st_reg.exec_cnt + 8'h01;
      case (op)
        ATD_OP_SHIFT: begin
          st_next.breg = st_reg.shift[7:4];
          st_next.acc = st_reg.shift[3:0];
        end
        ATD_OP_POINTER: begin
          st_next.acc = {1'b0, st_reg.pointer};
        end
        ATD_OP_CONV: begin
          if (st_reg.comparator_mode_sel) begin
            st_next.conv = {st_reg.breg, st_reg.acc};
          end else begin
            st_next.conv = st_reg.conv;
          end
        end
        ATD_OP_IRQ1: begin
          st_next.acc = st_reg.irq_ctrl_one;
        end
        ATD_OP_IRQ2: begin
          st_next.acc = st_reg.irq_ctrl_two;
        end
        ATD_OP_SER: begin
          st_next.acc = st_reg.serial_ctrl_reg;
        end
        ATD_OP_KEY0: begin
          st_next.acc = st_reg.key_wake_ctrl_zero;
        end
        default: begin
          // unknown word: flagged, only last_op and exec_cnt move besides; set beats a same-cycle clear
          st_next.illegal = 1'b1;
        end
      endcase
      // carry and skip are never touched by execution
      st_next.carry = st_reg.carry;
      st_next.skip_next = st_reg.skip_next;
    end
  end

  // read mux looks at next values so a read right after a write sees it
  always_comb begin
    rdata_next = 32'h0000_0000;
    // non-word sizes read back zero, as they write nothing
    if (hready && hsel && htrans[1] && (hsize == 3'h2) && !hwrite) begin
      if (req_next.addr == `ATD_OFF_ACC) begin
        rdata_next[3:0] = st_next.acc;
      end else if (req_next.addr == `ATD_OFF_BREG) begin
        rdata_next[3:0] = st_next.breg;
      end else if (req_next.addr == `ATD_OFF_SHIFT) begin
        rdata_next[7:0] = st_next.shift;
      end else if (req_next.addr == `ATD_OFF_POINTER) begin
        rdata_next[2:0] = st_next.pointer;
      end else if (req_next.addr == `ATD_OFF_CONV) begin
        rdata_next[7:0] = st_next.conv;
      end else if (req_next.addr == `ATD_OFF_CTRL) begin
        rdata_next[`ATD_CTRL_MODE_BIT] = st_next.comparator_mode_sel;
      end else if (req_next.addr == `ATD_OFF_IRQ_ONE) begin
        rdata_next[3:0] = st_next.irq_ctrl_one;
      end else if (req_next.addr == `ATD_OFF_IRQ_TWO) begin
        rdata_next[3:0] = st_next.irq_ctrl_two;
      end else if (req_next.addr == `ATD_OFF_SERIAL) begin
        rdata_next[3:0] = st_next.serial_ctrl_reg;
      end else if (req_next.addr == `ATD_OFF_KEY_ZERO) begin
        rdata_next[3:0] = st_next.key_wake_ctrl_zero;
      end else if (req_next.addr == `ATD_OFF_CARRY) begin
        rdata_next[0] = st_next.carry;
      end else if (req_next.addr == `ATD_OFF_STATUS) begin
        rdata_next[`ATD_STAT_ILLEGAL_BIT] = st_next.illegal;
        rdata_next[`ATD_STAT_SKIP_BIT] = st_next.skip_next;
        rdata_next[`ATD_STAT_OP_LSB +: 3] = st_next.last_op;
        rdata_next[`ATD_STAT_CNT_LSB +: 8] = st_next.exec_cnt;
      end
    end
  end

  // async assert only; release is taken at the next edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_reg <= '0;
      rdata_reg <= 32'h0000_0000;
      exec_reg <= 1'b0;
      st_reg.acc <= `ATD_RST_NIBBLE;
      st_reg.breg <= `ATD_RST_NIBBLE;
      st_reg.shift <= `ATD_RST_BYTE;
      st_reg.pointer <= `ATD_RST_POINTER;
      st_reg.conv <= `ATD_RST_BYTE;
      st_reg.comparator_mode_sel <= 1'b0;
      st_reg.irq_ctrl_one <= `ATD_RST_NIBBLE;
      st_reg.irq_ctrl_two <= `ATD_RST_NIBBLE;
      st_reg.serial_ctrl_reg <= `ATD_RST_NIBBLE;
      st_reg.key_wake_ctrl_zero <= `ATD_RST_NIBBLE;
      st_reg.carry <= 1'b0;
      st_reg.skip_next <= 1'b0;
      st_reg.illegal <= 1'b0;
      st_reg.last_op <= ATD_OP_NONE;
      st_reg.exec_cnt <= `ATD_RST_BYTE;
    end else begin
      req_reg <= req_next;
      rdata_reg <= rdata_next;
      exec_reg <= exec_next;
      st_reg <= st_next;
    end
  end

endmodule

`default_nettype wire

// *** design/atd_opcode_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "atd_cfg.svh"

module atd_opcode_decode (
  input wire logic [9:0] opcode,
  output atd_pkg::atd_op_t op
);
  import atd_pkg::*;

  always_comb begin
    if (opcode == `ATD_OP_SHIFT_TO_ACC) begin
      op = ATD_OP_SHIFT;
    end else if (opcode == `ATD_OP_POINTER_TO_ACC) begin
      op = ATD_OP_POINTER;
    end else if (opcode == `ATD_OP_ACC_TO_CONV) begin
      op = ATD_OP_CONV;
    end else if (opcode == `ATD_OP_IRQ_ONE) begin
      op = ATD_OP_IRQ1;
    end else if (opcode == `ATD_OP_IRQ_TWO) begin
      op = ATD_OP_IRQ2;
    end else if (opcode == `ATD_OP_SERIAL) begin
      op = ATD_OP_SER;
    end else if (opcode == `ATD_OP_KEY_ZERO) begin
      op = ATD_OP_KEY0;
    end else begin
      op = ATD_OP_NONE;
    end
  end

endmodule

`default_nettype wire

// *** tb/atd_core_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "atd_cfg.svh"
module atd_core_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [3:0] acc_out,
  input wire logic [3:0] breg_out,
  input wire logic [7:0] conv_out,
  input wire logic exec_pulse
);
  logic wr_reg;
  logic wr_next;
  logic ctl_wr_reg;
  logic mode_reg;
  // instruction data phase follows an accepted word write to offset zero
  assign wr_next = hsel && hready && htrans[1] && hwrite && hsize == 3'h2 && haddr[5:2] == 4'h0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) wr_reg <= 1'h0;
    else wr_reg <= wr_next;
  end
  // shadow of the comparator mode bit, taken from bus writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_wr_reg <= 1'h0;
      mode_reg <= 1'h0;
    end else begin
      ctl_wr_reg <= hsel && hready && htrans[1] && hwrite && hsize == 3'h2 && {haddr[5:2], 2'h0} == `ATD_OFF_CTRL;
      if (ctl_wr_reg) mode_reg <= hwdata[`ATD_CTRL_MODE_BIT];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_run(logic [9:0] op);
    wr_reg && hwdata[9:0] == op;
  endsequence
  a_exec_follows: assert property (wr_reg |=> exec_pulse)
    else $error("no retire pulse after instruction");
  a_exec_cause: assert property (exec_pulse |-> $past(wr_reg))
    else $error("retire pulse without instruction");
  a_ptr_top_zero: assert property (s_run(`ATD_OP_POINTER_TO_ACC) |=> acc_out[3] == 1'h0)
    else $error("pointer move left top bit set");
  a_ptr_b_hold: assert property (s_run(`ATD_OP_POINTER_TO_ACC) |=> $stable(breg_out) && $stable(conv_out))
    else $error("pointer move touched b or converter");
  a_conv_write: assert property (s_run(`ATD_OP_ACC_TO_CONV) |=> $stable(acc_out) && $stable(breg_out) &&
    conv_out == ($past(mode_reg) ? {$past(breg_out), $past(acc_out)} : $past(conv_out)))
    else $error("converter write wrong");
  a_read_b_hold: assert property (wr_reg && hwdata[9:0] inside {`ATD_OP_IRQ_ONE, `ATD_OP_IRQ_TWO,
    `ATD_OP_SERIAL, `ATD_OP_KEY_ZERO} |=> $stable(breg_out) && $stable(conv_out))
    else $error("control read touched b or converter");
  a_shift_conv_hold: assert property (s_run(`ATD_OP_SHIFT_TO_ACC) |=> $stable(conv_out))
    else $error("shift move touched converter");
  a_bus_okay: assert property (hresp == 1'h0 && hreadyout == 1'h1)
    else $error("bus response not okay");
endmodule
`default_nettype wire

// *** tb/atd_core_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "atd_cfg.svh"
module atd_core_tb;
  logic clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, exec_pulse, cy, sk;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize, mp;
  logic [3:0] acc_out, breg_out, ma, mb;
  logic [7:0] conv_out, msh, mc;
  logic [3:0] src [4];
  logic [9:0] ops [7];
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  int k;
  assign hready = hreadyout;
  atd_core u_dut (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hresp, .hrdata, .acc_out, .breg_out, .conv_out, .exec_pulse);
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  task give_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failures++;
      give_verdict();
    end
  end
  task check(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // hready and read data taken at the rising edge, before that edge's update lands
  task bus(input logic [5:0] a, input logic w, input logic [31:0] d);
    haddr <= {26'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'h1);
    r = hrdata;
  endtask
  task rd(input logic [5:0] a, input logic [31:0] e);
    bus(a, 1'h0, 32'h0);
    check(r, e);
  endtask
  initial begin
    rst_n = 1'h0;
    hsel = 1'h1;
    hsize = 3'h2;
    htrans = 2'h0;
    hwrite = 1'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    ops = '{`ATD_OP_SHIFT_TO_ACC, `ATD_OP_POINTER_TO_ACC, `ATD_OP_ACC_TO_CONV, `ATD_OP_IRQ_ONE,
      `ATD_OP_IRQ_TWO, `ATD_OP_SERIAL, `ATD_OP_KEY_ZERO};
    void'($urandom(4366));
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rd(`ATD_OFF_ACC, 32'h0);
    rd(`ATD_OFF_CONV, 32'h0);
    rd(`ATD_OFF_STATUS, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 28; i++) begin
      k = i % 7;
      ma = 4'($urandom);
      mb = 4'($urandom);
      msh = 8'($urandom);
      mp = 3'($urandom);
      mc = 8'($urandom);
      cy = 1'($urandom);
      sk = 1'($urandom);
      foreach (src[j]) src[j] = 4'($urandom);
      bus(`ATD_OFF_ACC, 1'h1, {28'h0, ma});
      bus(`ATD_OFF_BREG, 1'h1, {28'h0, mb});
      bus(`ATD_OFF_SHIFT, 1'h1, {24'h0, msh});
      bus(`ATD_OFF_POINTER, 1'h1, {29'h0, mp});
      bus(`ATD_OFF_CONV, 1'h1, {24'h0, mc});
      bus(`ATD_OFF_CTRL, 1'h1, {31'h0, i[0]});
      bus(`ATD_OFF_IRQ_ONE, 1'h1, {28'h0, src[0]});
      bus(`ATD_OFF_IRQ_TWO, 1'h1, {28'h0, src[1]});
      bus(`ATD_OFF_SERIAL, 1'h1, {28'h0, src[2]});
      bus(`ATD_OFF_KEY_ZERO, 1'h1, {28'h0, src[3]});
      bus(`ATD_OFF_CARRY, 1'h1, {31'h0, cy});
      bus(`ATD_OFF_STATUS, 1'h1, {30'h0, sk, 1'h1});
      bus(`ATD_OFF_INSTR, 1'h1, {22'h0, ops[k]});
      case (k)
        0: {mb, ma} = msh;
        1: ma = {1'h0, mp};
        2: if (i[0]) mc = {mb, ma};
        default: ma = src[k - 3];
      endcase
      rd(`ATD_OFF_ACC, {28'h0, ma});
      rd(`ATD_OFF_BREG, {28'h0, mb});
      rd(`ATD_OFF_CONV, {24'h0, mc});
      check({16'h0, conv_out, breg_out, acc_out}, {16'h0, mc, mb, ma});
      rd(`ATD_OFF_CARRY, {31'h0, cy});
      bus(`ATD_OFF_STATUS, 1'h0, 32'h0);
      check({31'h0, r[1]}, {31'h0, sk});
      check({24'h0, r[15:8]}, 32'(i + 1));
      check({29'h0, r[6:4]}, 32'(k + 1));
      $display("test %0d done", i);
    end
    // corner case: a word outside the group moves nothing but the flag, the last op and the count
    bus(`ATD_OFF_INSTR, 1'h1, 32'h0000_03FF);
    rd(`ATD_OFF_ACC, {28'h0, ma});
    rd(`ATD_OFF_CARRY, {31'h0, cy});
    bus(`ATD_OFF_STATUS, 1'h0, 32'h0);
    check({30'h0, r[1:0]}, {30'h0, sk, 1'h1});
    check({24'h0, r[15:8]}, 32'h0000_001D);
    check({29'h0, r[6:4]}, 32'h0000_0000);
    $display("unknown opcode test done");
    give_verdict();
  end
endmodule
bind atd_core atd_core_assertions u_chk (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
  .hready, .hreadyout, .hresp, .acc_out, .breg_out, .conv_out, .exec_pulse);
`default_nettype wire
